// [rtl/uart_buffer_defines.svh]
`ifndef UART_BUFFER_DEFINES_SVH
`define UART_BUFFER_DEFINES_SVH

// Command codes
`define CMD_TX_CLEAR 8'h20
`define CMD_MSG_READ 8'h91
`define CMD_OLDEST_READ 8'h93
`define CMD_RX_CLEAR 8'hE0
// Upper nibble of the load-queue command groups
`define NIB_LQ_ACCESS 4'hC
`define NIB_LQ_ADVANCE 4'hB
// Highest low nibble inside a load-queue group (location 6)
`define NIB_LQ_TOP 4'hD
// Load-queue geometry
`define LQ_LOCS 7
`define LQ_LAST_LOC 3'h6
`define LQ_PAST_END 3'h7
// Byte framing
`define BIT_FIRST 3'h0
`define BIT_LAST 3'h7
`define ZERO_BYTE 8'h00

`endif

// [rtl/uart_buffer_pkg.sv]
package uart_buffer_pkg;

	// Command phase of one chip-select frame
	typedef enum logic [4:0] {
		ST_CMD = 5'b00001,
		ST_LQWR = 5'b00010,
		ST_LQRD = 5'b00100,
		ST_RXRD = 5'b01000,
		ST_SKIP = 5'b10000
	} cmd_state_t;

	// Serial port pins as they arrive from the host
	typedef struct packed {
		logic sclk;
		logic csN;
		logic mosi;
	} spi_pins_t;

	// One byte from the UART receiver, same clock as the block
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} rx_write_t;

endpackage

// [rtl/uart_buffer_spi_commands.sv]
// Overview of operation
// - Commands C0..CC write load queue from chosen location; past location 6 ignored.
// - Commands C1..CD read load queue from chosen location; past location 6 reads zero.
// - Command E0 returns receive buffer and its pointers to reset state.
// - Write pointer stalls one behind read pointer; overflow flag is raised.
// - In overflow each new byte overwrites the last stored byte.
// - Command 91 reads receive buffer from current read pointer.
// - Command 93 reads receive buffer from start of oldest unread message.
// - After a message's final byte, reads return 00 and never enter next message.
// - Read pointer advances only after a whole byte is shifted out.
// - Each receive byte read is cleared and freed for new data.
// - Command 20 clears transmit buffer, transmit queue and load-queue pointers.
// - Commands B0..BC advance load-queue pointer, then write; advance occurs regardless.
`timescale 1ns/1ns
`include "uart_buffer_defines.svh"

module uart_buffer_spi_commands #(
	parameter int RX_DEPTH = 62,
	parameter int QUEUES = 4,
	parameter int RW = $clog2(RX_DEPTH),
	parameter int QW = $clog2(QUEUES)
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire uart_buffer_pkg::spi_pins_t spiIn,
	output logic miso,
	input wire uart_buffer_pkg::rx_write_t rxWrite,
	input wire logic txSent,
	output logic rxOverflow,
	output logic rxEmpty,
	output logic [QW-1:0] ldqPtr,
	output logic [QW-1:0] txqPtr
);
	import uart_buffer_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [RW-1:0] incRx(input logic [RW-1:0] p);
		incRx = (p == RW'(RX_DEPTH - 1)) ? '0 : p + RW'(1);
	endfunction

	function automatic logic [RW-1:0] decRx(input logic [RW-1:0] p);
		decRx = (p == '0) ? RW'(RX_DEPTH - 1) : p - RW'(1);
	endfunction

	function automatic logic [QW-1:0] incQ(input logic [QW-1:0] p);
		incQ = (p == QW'(QUEUES - 1)) ? '0 : p + QW'(1);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the host clock is far slower than ref_clk

	spi_pins_t pinS1_q, pinS2_q;
	logic sclkPrev_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pinS1_q <= '{sclk: 1'b0, csN: 1'b1, mosi: 1'b0};
			pinS2_q <= '{sclk: 1'b0, csN: 1'b1, mosi: 1'b0};
			sclkPrev_q <= 1'b0;
		end else begin
			pinS1_q <= spiIn;
			pinS2_q <= pinS1_q;
			sclkPrev_q <= pinS2_q.sclk;
		end
	end

	// Mode 0: sample on rising edge, shift out on falling edge
	logic csActive, sclkRise, sclkFall;
	assign csActive = ~pinS2_q.csN;
	assign sclkRise = csActive & pinS2_q.sclk & ~sclkPrev_q;
	assign sclkFall = csActive & ~pinS2_q.sclk & sclkPrev_q;

	////////////////////////////////////////////////////////////////////////////
	// Command and buffer state

	cmd_state_t state_q, state_d;
	logic [2:0] bitCnt_q, bitCnt_d;
	logic [7:0] inShift_q, inShift_d;
	logic [7:0] outShift_q, outShift_d;
	logic [2:0] idx_q, idx_d;
	logic msgDone_q, msgDone_d;
	logic [QW-1:0] ldq_q, ldq_d, txq_q, txq_d;
	logic [QUEUES-1:0][`LQ_LOCS-1:0][7:0] lq_q, lq_d;
	logic [RX_DEPTH-1:0][7:0] rxMem_q, rxMem_d;
	logic [RX_DEPTH-1:0] rxLast_q, rxLast_d;
	logic [RW-1:0] wr_q, wr_d, rd_q, rd_d, nxt_q, nxt_d;
	logic ovf_q, ovf_d, empty_q, empty_d;

	logic [7:0] rxByte, nextOut;
	logic byteDone, cmdDone, rxAvail;
	assign rxByte = {inShift_q[6:0], pinS2_q.mosi};
	assign byteDone = sclkRise & (bitCnt_q == `BIT_LAST);
	assign cmdDone = byteDone & (state_q == ST_CMD);
	assign rxAvail = ~msgDone_q & (rd_q != wr_q);

	// Byte presented at the start of each data byte
	always_comb begin
		case (state_q)
			ST_LQRD: nextOut = (idx_q <= `LQ_LAST_LOC) ? lq_q[ldq_q][idx_q] : `ZERO_BYTE;
			ST_RXRD: nextOut = rxAvail ? rxMem_q[rd_q] : `ZERO_BYTE;
			default: nextOut = `ZERO_BYTE;
		endcase
	end

	// Next values; clears act before the UART store so a byte in the same cycle survives
	always_comb begin
		state_d = state_q;
		bitCnt_d = bitCnt_q;
		inShift_d = inShift_q;
		outShift_d = outShift_q;
		idx_d = idx_q;
		msgDone_d = msgDone_q;
		ldq_d = ldq_q;
		txq_d = txq_q;
		lq_d = lq_q;
		rxMem_d = rxMem_q;
		rxLast_d = rxLast_q;
		wr_d = wr_q;
		rd_d = rd_q;
		nxt_d = nxt_q;
		ovf_d = ovf_q;
		if (txSent) begin
			txq_d = incQ(txq_q);
		end
		if (!csActive) begin
			state_d = ST_CMD;
			bitCnt_d = `BIT_FIRST;
			outShift_d = `ZERO_BYTE;
		end else begin
			if (sclkRise) begin
				inShift_d = rxByte;
				bitCnt_d = bitCnt_q + 3'h1;
			end
			if (byteDone) begin
				case (state_q)
					ST_CMD: begin
						state_d = ST_SKIP;
						idx_d = rxByte[3:1];
						msgDone_d = 1'b0;
						if (rxByte[7:4] == `NIB_LQ_ACCESS && rxByte[3:0] <= `NIB_LQ_TOP) begin
							state_d = rxByte[0] ? ST_LQRD : ST_LQWR;
						end else if (rxByte[7:4] == `NIB_LQ_ADVANCE && rxByte[3:0] <= `NIB_LQ_TOP
							&& !rxByte[0]) begin
							ldq_d = incQ(ldq_q);
							state_d = ST_LQWR;
						end else if (rxByte == `CMD_MSG_READ) begin
							state_d = ST_RXRD;
						end else if (rxByte == `CMD_OLDEST_READ) begin
							state_d = ST_RXRD;
							rd_d = nxt_q;
						end else if (rxByte == `CMD_TX_CLEAR) begin
							lq_d = '0;
							ldq_d = '0;
							txq_d = '0;
						end else if (rxByte == `CMD_RX_CLEAR) begin
							rxMem_d = '0;
							rxLast_d = '0;
							wr_d = '0;
							rd_d = '0;
							nxt_d = '0;
							ovf_d = 1'b0;
						end
					end
					ST_LQWR: begin
						if (idx_q <= `LQ_LAST_LOC) begin
							lq_d[ldq_q][idx_q] = rxByte;
							idx_d = idx_q + 3'h1;
						end
					end
					ST_LQRD: begin
						if (idx_q <= `LQ_LAST_LOC) begin
							idx_d = idx_q + 3'h1;
						end
					end
					ST_RXRD: begin
						// Commit only here, after the last bit went out
						if (rxAvail) begin
							rxMem_d[rd_q] = `ZERO_BYTE;
							rxLast_d[rd_q] = 1'b0;
							rd_d = incRx(rd_q);
							if (rxLast_q[rd_q]) begin
								msgDone_d = 1'b1;
								nxt_d = incRx(rd_q);
							end
						end
					end
					default: ;
				endcase
			end
			if (sclkFall) begin
				outShift_d = (bitCnt_q == `BIT_FIRST) ? nextOut : {outShift_q[6:0], 1'b0};
			end
		end
		// UART store; on a full ring the newest byte is replaced rather than dropped silently
		if (rxWrite.valid) begin
			if (incRx(wr_d) == rd_d) begin
				ovf_d = 1'b1;
				rxMem_d[decRx(wr_d)] = rxWrite.data;
				rxLast_d[decRx(wr_d)] = rxWrite.last;
			end else begin
				rxMem_d[wr_d] = rxWrite.data;
				rxLast_d[wr_d] = rxWrite.last;
				wr_d = incRx(wr_d);
			end
		end
		empty_d = (wr_d == rd_d);
	end

	// State registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_CMD;
			bitCnt_q <= `BIT_FIRST;
			inShift_q <= `ZERO_BYTE;
			outShift_q <= `ZERO_BYTE;
			idx_q <= `LQ_PAST_END;
			msgDone_q <= 1'b0;
			ldq_q <= '0;
			txq_q <= '0;
			lq_q <= '0;
			rxMem_q <= '0;
			rxLast_q <= '0;
			wr_q <= '0;
			rd_q <= '0;
			nxt_q <= '0;
			ovf_q <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			state_q <= state_d;
			bitCnt_q <= bitCnt_d;
			inShift_q <= inShift_d;
			outShift_q <= outShift_d;
			idx_q <= idx_d;
			msgDone_q <= msgDone_d;
			ldq_q <= ldq_d;
			txq_q <= txq_d;
			lq_q <= lq_d;
			rxMem_q <= rxMem_d;
			rxLast_q <= rxLast_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			nxt_q <= nxt_d;
			ovf_q <= ovf_d;
			empty_q <= empty_d;
		end
	end

	// Outputs straight from flops
	assign miso = outShift_q[7];
	assign rxOverflow = ovf_q;
	assign rxEmpty = empty_q;
	assign ldqPtr = ldq_q;
	assign txqPtr = txq_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic loadByte;
	assign loadByte = sclkFall & (bitCnt_q == `BIT_FIRST);

	lq_write_end_a: assert property (byteDone && state_q == ST_LQWR
		&& idx_q == `LQ_PAST_END |=> $stable(lq_q)) else $error("queue written past end");
	lq_read_end_a: assert property (loadByte && state_q == ST_LQRD
		&& idx_q > `LQ_LAST_LOC |=> outShift_q == `ZERO_BYTE) else $error("tail not zero");
	rx_clear_a: assert property (cmdDone && rxByte == `CMD_RX_CLEAR && !rxWrite.valid
		|=> wr_q == '0 && rd_q == '0 && nxt_q == '0 && !ovf_q) else $error("rx clear");
	rx_stall_a: assert property (!csActive && rxWrite.valid && incRx(wr_q) == rd_q
		|=> ovf_q && wr_q == $past(wr_q)) else $error("write pointer not stalled");
	rx_overwrite_a: assert property (!csActive && rxWrite.valid && incRx(wr_q) == rd_q
		|=> rxMem_q[decRx(wr_q)] == $past(rxWrite.data)) else $error("last byte kept");
	msg_first_a: assert property (loadByte && state_q == ST_RXRD && rxAvail
		|=> outShift_q == $past(rxMem_q[rd_q])) else $error("wrong byte at read pointer");
	oldest_start_a: assert property (cmdDone && rxByte == `CMD_OLDEST_READ
		|=> rd_q == $past(nxt_q)) else $error("oldest read not at message start");
	msg_end_a: assert property (loadByte && state_q == ST_RXRD && msgDone_q
		|=> outShift_q == `ZERO_BYTE ##1 rd_q == $past(rd_q, 2)) else $error("read ran on");
	abort_hold_a: assert property (!byteDone |=> rd_q == $past(rd_q))
		else $error("read pointer moved without a whole byte");
	byte_clear_a: assert property (byteDone && state_q == ST_RXRD && rxAvail
		&& !rxWrite.valid |=> rxMem_q[$past(rd_q)] == `ZERO_BYTE
		&& rd_q == incRx($past(rd_q))) else $error("read byte not freed");
	tx_clear_a: assert property (cmdDone && rxByte == `CMD_TX_CLEAR
		|=> ldq_q == '0 && txq_q == '0 && lq_q == '0) else $error("tx clear failed");
	lq_advance_a: assert property (cmdDone && rxByte[7:4] == `NIB_LQ_ADVANCE
		&& rxByte[3:0] <= `NIB_LQ_TOP && !rxByte[0]
		|=> ldq_q == incQ($past(ldq_q)) && state_q == ST_LQWR) else $error("no advance");
	frame_end_a: assert property (!csActive
		|=> state_q == ST_CMD && bitCnt_q == `BIT_FIRST) else $error("deselect ignored");

	lq_read_c: cover property (byteDone && state_q == ST_LQRD && idx_q == `LQ_LAST_LOC);
	msg_done_c: cover property (loadByte && state_q == ST_RXRD && msgDone_q);
	overflow_c: cover property (rxWrite.valid && incRx(wr_q) == rd_q);
	oldest_c: cover property (cmdDone && rxByte == `CMD_OLDEST_READ);

endmodule

// [tb/spi_host_model.sv]
`timescale 1ns/1ns
module spi_host_model
	import uart_buffer_pkg::*;
(
	input wire logic ref_clk,
	input wire logic miso,
	output uart_buffer_pkg::spi_pins_t spiIn
);
	// Half of the 160 ns serial period, in block clock cycles
	localparam int HALF = 20;

	initial spiIn = '{sclk: 1'b0, csN: 1'b1, mosi: 1'b0};

	// Pins move just after a block clock edge, never on it
	task automatic waitClk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Gap keeps deselect well above three block cycles
	task automatic start();
		waitClk(10);
		spiIn.csN = 1'b0;
		waitClk(HALF);
	endtask

	// Mode 0, MSB first; fewer than 8 bits models an aborted byte
	task automatic xfer(input logic [7:0] tx, input int nBits, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nBits; i--) begin
			spiIn.mosi = tx[i];
			waitClk(HALF);
			spiIn.sclk = 1'b1;
			rx[i] = miso;
			waitClk(HALF);
			spiIn.sclk = 1'b0;
		end
	endtask

	// Released data line must not look like the last bit
	task automatic stop();
		waitClk(HALF);
		spiIn.csN = 1'b1;
		spiIn.mosi = ~spiIn.mosi;
	endtask
endmodule

// [tb/uart_buffer_spi_commands_tb.sv]
`timescale 1ns/1ns
module uart_buffer_spi_commands_tb;
	import uart_buffer_pkg::*;
	logic ref_clk;
	logic rst;
	spi_pins_t spiIn;
	logic miso;
	rx_write_t rxWrite;
	logic txSent;
	logic rxOverflow;
	logic rxEmpty;
	logic [1:0] ldqPtr;
	logic [1:0] txqPtr;
	int errors = 0;
	int numChecks = 0;
	int ldq;
	logic [7:0] txBuf [64];
	logic [7:0] rxBuf [64];
	logic [7:0] rxExp [64];
	logic [7:0] lq [4][7];

	uart_buffer_spi_commands dut (.ref_clk(ref_clk), .rst(rst), .spiIn(spiIn), .miso(miso),
		.rxWrite(rxWrite), .txSent(txSent), .rxOverflow(rxOverflow), .rxEmpty(rxEmpty),
		.ldqPtr(ldqPtr), .txqPtr(txqPtr));
	spi_host_model host (.ref_clk(ref_clk), .miso(miso), .spiIn(spiIn));

	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", numChecks, errors);
		if (errors == 0 && numChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		numChecks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Bytes past the last location read back as zero
	function automatic logic [7:0] lqExp(input int loc);
		return (loc < 7) ? lq[ldq][loc] : 8'h00;
	endfunction

	// One framed command plus n whole bytes and an optional partial one
	task automatic frame(input logic [7:0] cmd, input int n, input int cut);
		logic [7:0] r;
		host.start();
		host.xfer(cmd, 8, r);
		check(r, 8'h00, "command slot");
		for (int i = 0; i < n; i++) begin
			host.xfer(txBuf[i], 8, rxBuf[i]);
		end
		if (cut > 0) begin
			host.xfer(8'hFF, cut, r);
		end
		host.stop();
	endtask

	task automatic readLq(input int s);
		frame(8'hC1 + 8'(2 * s), 8 - s, 0);
		for (int i = 0; i < 8 - s; i++) begin
			check(rxBuf[i], lqExp(s + i), "queue byte");
		end
	endtask

	task automatic clearTx();
		frame(8'h20, 0, 0);
		foreach (lq[a, b]) lq[a][b] = 8'h00;
		ldq = 0;
	endtask

	// Last flag on the final byte closes each message
	task automatic push(input int first, input int n);
		for (int i = first; i < first + n; i++) begin
			rxExp[i] = 8'($urandom);
			rxWrite = '{valid: 1'b1, last: (i == first + n - 1), data: rxExp[i]};
			tick(1);
			rxWrite.valid = 1'b0;
			tick(1);
		end
	endtask

	// Status is polled with a bound, never trusted after one look
	task automatic waitFlag(input logic want);
		for (int i = 0; i < 50 && rxEmpty !== want; i++) begin
			tick(1);
		end
		check({7'h00, rxEmpty}, {7'h00, want}, "empty flag");
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (90000) @(posedge ref_clk);
		errors++;
		complete_run();
	end

	// Main sequence
	initial begin
		void'($urandom(80613));
		// Long reads shift these out on the data line; keep them known
		foreach (txBuf[i]) txBuf[i] = 8'($urandom);
		rst = 1'b1;
		txSent = 1'b0;
		rxWrite = '0;
		repeat (6) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		tick(3);
		check({7'h00, rxEmpty}, 8'h01, "reset empty");
		check({2'h0, ldqPtr, txqPtr, rxOverflow, miso}, 8'h00, "reset outputs");
		clearTx();
		// Every write start location, one byte more than fits
		for (int s = 0; s < 7; s++) begin
			for (int i = 0; i < 8; i++) begin
				txBuf[i] = 8'($urandom);
			end
			frame(8'hC0 + 8'(2 * s), 8 - s, 0);
			for (int i = s; i < 7; i++) begin
				lq[0][i] = txBuf[i - s];
			end
			readLq(s);
		end
		readLq(0);
		repeat (5) begin
			txSent = 1'b1;
			tick(1);
			txSent = 1'b0;
			tick(1);
		end
		check({6'h00, txqPtr}, 8'h01, "tx pointer wrap");
		frame(8'hB0, 0, 0);
		check({6'h00, ldqPtr}, 8'h01, "advance without data");
		txBuf[0] = 8'h5A;
		txBuf[1] = 8'hA5;
		frame(8'hBC, 2, 0);
		ldq = 2;
		lq[2][6] = 8'h5A;
		readLq(6);
		check({6'h00, ldqPtr}, 8'h02, "advance then write");
		clearTx();
		check({4'h0, ldqPtr, txqPtr}, 8'h00, "tx clear pointers");
		readLq(0);
		// Refused command stays silent; a cut data byte is never stored
		frame(8'h95, 2, 0);
		check(rxBuf[0] | rxBuf[1], 8'h00, "ignored command");
		check({6'h00, ldqPtr}, 8'h00, "ignored command pointer");
		frame(8'hC0, 1, 5);
		lq[0][0] = txBuf[0];
		readLq(0);
		// Two messages, first read is cut inside its second byte
		push(0, 3);
		push(3, 2);
		waitFlag(1'b0);
		frame(8'h91, 1, 3);
		check(rxBuf[0], rxExp[0], "read pointer start");
		frame(8'h91, 4, 0);
		check(rxBuf[0], rxExp[1], "resent byte");
		check(rxBuf[1], rxExp[2], "message tail");
		check(rxBuf[2] | rxBuf[3], 8'h00, "past message end");
		frame(8'h93, 3, 0);
		check(rxBuf[0], rxExp[3], "oldest message");
		check(rxBuf[1], rxExp[4], "oldest message tail");
		check(rxBuf[2], 8'h00, "no next message");
		waitFlag(1'b1);
		// Fill past capacity: write pointer stalls, last slot overwritten
		push(0, 63);
		check({7'h00, rxOverflow}, 8'h01, "overflow flag");
		frame(8'h91, 62, 0);
		for (int i = 0; i < 60; i++) begin
			check(rxBuf[i], rxExp[i], "stored byte");
		end
		check(rxBuf[60], rxExp[62], "overwritten byte");
		check(rxBuf[61], 8'h00, "end after overflow");
		frame(8'hE0, 0, 0);
		check({6'h00, rxOverflow, rxEmpty}, 8'h01, "rx clear flags");
		frame(8'h91, 1, 0);
		check(rxBuf[0], 8'h00, "cleared buffer");
		complete_run();
	end
endmodule
